// *** core/mamx_exec.v ***
// move-to-coprocessor, product register moves and multiply execution
`timescale 1ns/1ps
`include "mamx_map.vh"
module mamx_exec (
   input wire clock,
   input wire rstn,
   input wire instr_valid,
   input wire [31:0] instr,
   input wire [63:0] src_a_value,
   input wire [63:0] src_b_value,
   input wire fpu_usable,
   input wire cp2_usable,
   input wire [1:0] fp_round_mode,
   input wire fp_reg32_mode,
   input wire md_start,
   input wire md_wr,
   input wire [63:0] md_upper,
   input wire [63:0] md_bottom,
   output reg instr_ready_q,
   output reg done_q,
   output reg gpr_wr_en_q,
   output reg [4:0] gpr_wr_addr_q,
   output reg [63:0] gpr_wr_data_q,
   output reg cp2_wr_en_q,
   output reg [4:0] cp2_wr_reg_q,
   output reg [2:0] cp2_wr_sel_q,
   output reg [31:0] cp2_wr_data_q,
   output reg [63:0] upper_product_reg_q,
   output reg [63:0] bottom_product_word_reg_q,
   output reg product_ready_q,
   output reg exc_cop_unusable_q,
   output reg [1:0] exc_cop_num_q,
   output reg exc_reserved_q,
   output reg [3:0] fp_cause_q
);

localparam ST_IDLE = 1'b0;
localparam ST_EXEC = 1'b1;

reg state_q;
reg [31:0] instr_q;
reg [63:0] a_q;
reg [63:0] b_q;

// low word of a signed 32x32 product, sign-extended to 64 bits
function [63:0] mamx_mul_low;
   input [31:0] x;
   input [31:0] z;
   reg [63:0] full;
   begin
      full = $signed({{32{x[31]}}, x}) * $signed({{32{z[31]}}, z});
      mamx_mul_low = {{32{full[31]}}, full[31:0]};
   end
endfunction

// fields of the held instruction
wire [5:0] op = instr_q[`MAMX_OP_MSB:`MAMX_OP_LSB];
wire [4:0] sub = instr_q[`MAMX_SUB_MSB:`MAMX_SUB_LSB];
wire [4:0] rd = instr_q[`MAMX_RD_MSB:`MAMX_RD_LSB];
wire [4:0] fdst = instr_q[`MAMX_FDEST_MSB:`MAMX_FDEST_LSB];
wire [5:0] fn = instr_q[`MAMX_FN_MSB:`MAMX_FN_LSB];

// decode; every recognised form checks its must-be-zero bits
wire is_mv_fpu = (op == `MAMX_OP_FPU_GROUP) &&
   (sub == `MAMX_MOVE_TO_SUBOP) && (instr_q[10:0] == 11'h000);
wire is_mv_cp2 = (op == `MAMX_OP_CP2_GROUP) &&
   (sub == `MAMX_MOVE_TO_SUBOP) && (instr_q[10:3] == 8'h00);
wire is_wr_up = (op == `MAMX_OP_SPECIAL) &&
   (instr_q[20:6] == 15'h0000) && (fn == `MAMX_FN_WR_UPPER);
wire is_wr_bot = (op == `MAMX_OP_SPECIAL) &&
   (instr_q[20:6] == 15'h0000) && (fn == `MAMX_FN_WR_BOTTOM);
wire is_pmul = (op == `MAMX_OP_SECOND_SPECIAL_OPCODE_GROUP) && (fdst == 5'h00) &&
   (fn == `MAMX_FN_PROD_TO_REG);
wire is_fmul = (op == `MAMX_OP_FPU_GROUP) && sub[4] &&
   (fn == `MAMX_FN_FP_PRODUCT);
wire fmt_s = (sub == `MAMX_FMT_SINGLE);
wire fmt_d = (sub == `MAMX_FMT_DOUBLE);
wire fmt_pair = (sub == `MAMX_FMT_PAIRED);

// float register reads are addressed from the incoming word
wire [63:0] fr_a;
wire [63:0] fr_b;
reg fr_wr_en;
reg [4:0] fr_wr_addr;
reg [63:0] fr_wr_data;

mamx_fpregs u_fpregs (
   .clock(clock),
   .rstn(rstn),
   .rd_addr_a(instr[`MAMX_RD_MSB:`MAMX_RD_LSB]),
   .rd_addr_b(instr[`MAMX_SRCB_MSB:`MAMX_SRCB_LSB]),
   .rd_data_a(fr_a),
   .rd_data_b(fr_b),
   .wr_en(fr_wr_en),
   .wr_addr(fr_wr_addr),
   .wr_data(fr_wr_data)
);

wire [63:0] dbl_y;
wire [3:0] dbl_fx;
wire [31:0] shi_y;
wire [3:0] shi_fx;
wire [31:0] slo_y;
wire [3:0] slo_fx;

// double datapath plus two single lanes for the paired format
mamx_fpmul #(.EW(11), .MW(52)) u_mul_dbl (
   .a(fr_a),
   .b(fr_b),
   .rmode(fp_round_mode),
   .y(dbl_y),
   .flags(dbl_fx)
);

mamx_fpmul #(.EW(8), .MW(23)) u_mul_shi (
   .a(fr_a[63:32]),
   .b(fr_b[63:32]),
   .rmode(fp_round_mode),
   .y(shi_y),
   .flags(shi_fx)
);

mamx_fpmul #(.EW(8), .MW(23)) u_mul_slo (
   .a(fr_a[31:0]),
   .b(fr_b[31:0]),
   .rmode(fp_round_mode),
   .y(slo_y),
   .flags(slo_fx)
);

// exception classes; unusable coprocessor outranks a bad format
wire fpu_trap = (is_mv_fpu | is_fmul) & ~fpu_usable;
wire cp2_trap = is_mv_cp2 & ~cp2_usable;
wire fmt_bad = is_fmul & fpu_usable & ~(fmt_s | fmt_d | fmt_pair);

// float register write port: only in the execute cycle
always @*
begin
   fr_wr_en = 1'b0;
   fr_wr_addr = rd;
   fr_wr_data = fr_a;
   if (state_q == ST_EXEC && !fpu_trap)
   begin
      if (is_mv_fpu)
      begin
         fr_wr_en = 1'b1;
         // upper half cleared: stale or unset bits would poison pair lanes
         fr_wr_data = {32'h0000_0000, b_q[31:0]};
      end
      else if (is_fmul && !fmt_bad)
      begin
         fr_wr_en = 1'b1;
         fr_wr_addr = fdst;
         if (fmt_d)
         begin
            fr_wr_data = dbl_y;
         end
         else if (fmt_pair)
         begin
            // lanes run regardless of register mode
            fr_wr_data = {shi_y, slo_y};
         end
         else
         begin
            fr_wr_data = {fr_a[63:32], slo_y};
         end
      end
   end
end

// two-cycle sequence: accept, then execute and write back
always @(posedge clock or negedge rstn)
begin
   if (!rstn)
   begin
      state_q <= ST_IDLE;
      instr_q <= 32'h0000_0000;
      a_q <= `MAMX_RST_WORD;
      b_q <= `MAMX_RST_WORD;
      instr_ready_q <= 1'b1;
      done_q <= 1'b0;
      gpr_wr_en_q <= 1'b0;
      gpr_wr_addr_q <= 5'h00;
      gpr_wr_data_q <= `MAMX_RST_WORD;
      cp2_wr_en_q <= 1'b0;
      cp2_wr_reg_q <= 5'h00;
      cp2_wr_sel_q <= 3'h0;
      cp2_wr_data_q <= 32'h0000_0000;
      exc_cop_unusable_q <= 1'b0;
      exc_cop_num_q <= `MAMX_RST_COP_NUM;
      exc_reserved_q <= 1'b0;
      fp_cause_q <= 4'h0;
   end
   else
   begin
      done_q <= 1'b0;
      gpr_wr_en_q <= 1'b0;
      cp2_wr_en_q <= 1'b0;
      exc_cop_unusable_q <= 1'b0;
      exc_reserved_q <= 1'b0;
      case (state_q)
         ST_IDLE:
         begin
            if (instr_valid)
            begin
               instr_q <= instr;
               a_q <= src_a_value;
               b_q <= src_b_value;
               instr_ready_q <= 1'b0;
               state_q <= ST_EXEC;
            end
         end
         default:
         begin
            // next word is accepted only after the write lands
            instr_ready_q <= 1'b1;
            done_q <= 1'b1;
            state_q <= ST_IDLE;
            if (fpu_trap || cp2_trap)
            begin
               exc_cop_unusable_q <= 1'b1;
               exc_cop_num_q <= fpu_trap ? 2'h1 : 2'h2;
            end
            else if (fmt_bad)
            begin
               exc_reserved_q <= 1'b1;
            end
            else if (is_mv_cp2)
            begin
               // no existence check on reg/sel
               cp2_wr_en_q <= 1'b1;
               cp2_wr_reg_q <= rd;
               cp2_wr_sel_q <= instr_q[2:0];
               cp2_wr_data_q <= b_q[31:0];
            end
            else if (is_pmul)
            begin
               // no overflow trap; high source bits ignored
               gpr_wr_en_q <= 1'b1;
               gpr_wr_addr_q <= rd;
               gpr_wr_data_q <= mamx_mul_low(a_q[31:0], b_q[31:0]);
            end
            else if (is_fmul)
            begin
               if (fmt_d)
               begin
                  fp_cause_q <= dbl_fx;
               end
               else if (fmt_pair)
               begin
                  fp_cause_q <= shi_fx | slo_fx;
               end
               else
               begin
                  fp_cause_q <= slo_fx;
               end
            end
         end
      endcase
   end
end

wire exec_ok = (state_q == ST_EXEC) && !fpu_trap && !cp2_trap;

// product pair; an instruction write beats a same-cycle unit result
always @(posedge clock or negedge rstn)
begin
   if (!rstn)
   begin
      upper_product_reg_q <= `MAMX_RST_WORD;
      bottom_product_word_reg_q <= `MAMX_RST_WORD;
   end
   else
   begin
      // unit results never come from product_to_register
      if (md_wr)
      begin
         upper_product_reg_q <= md_upper;
         bottom_product_word_reg_q <= md_bottom;
      end
      // only the named half moves; the other may be stale
      if (exec_ok && is_wr_up)
      begin
         upper_product_reg_q <= a_q;
      end
      if (exec_ok && is_wr_bot)
      begin
         bottom_product_word_reg_q <= a_q;
      end
   end
end

// readers hold off after a launch until the unit writes back or an instruction writes a half; a same-cycle write beats the launch
always @(posedge clock or negedge rstn)
begin
   if (!rstn)
   begin
      product_ready_q <= 1'b1;
   end
   else if (md_wr || (exec_ok && (is_wr_up || is_wr_bot)))
   begin
      product_ready_q <= 1'b1;
   end
   else if (md_start)
   begin
      product_ready_q <= 1'b0;
   end
end

endmodule // mamx_exec

// *** core/mamx_fpmul.v ***
// combinational binary float multiply, subnormals flushed to zero
`timescale 1ns/1ps
`include "mamx_map.vh"
module mamx_fpmul #(
   parameter EW = 8,
   parameter MW = 23
) (
   input wire [EW+MW:0] a,
   input wire [EW+MW:0] b,
   input wire [1:0] rmode,
   output reg [EW+MW:0] y,
   output reg [3:0] flags
);

localparam PW = 2*MW+2;
localparam [EW+1:0] BIASW = {3'b000, {(EW-1){1'b1}}};
localparam [EW+1:0] EMAX = {2'b00, {EW{1'b1}}};

wire sa = a[EW+MW];
wire sb = b[EW+MW];
wire [EW-1:0] ea = a[EW+MW-1:MW];
wire [EW-1:0] eb = b[EW+MW-1:MW];
wire [MW-1:0] ma = a[MW-1:0];
wire [MW-1:0] mb = b[MW-1:0];
wire s = sa ^ sb;

// operand classes; exponent zero counts as zero (flush)
wire za = ~|ea;
wire zb = ~|eb;
wire ia = (&ea) & ~|ma;
wire ib = (&eb) & ~|mb;
wire na = (&ea) & |ma;
wire nb = (&eb) & |mb;

// exact significand product, normalised to a leading one
wire [PW-1:0] p = {{(MW+1){1'b0}}, 1'b1, ma} * {{(MW+1){1'b0}}, 1'b1, mb};
wire pmsb = p[PW-1];
wire [PW-1:0] pn = pmsb ? p : {p[PW-2:0], 1'b0};
wire [MW:0] keep = pn[PW-1 -: MW+1];
wire g = pn[PW-MW-2];
wire st = |pn[PW-MW-3:0];
wire [EW+1:0] e = {2'b00, ea} + {2'b00, eb} + {{(EW+1){1'b0}}, pmsb} - BIASW;

reg up;
reg ovf_inf;

// rounding increment and overflow target per mode
always @*
begin
   case (rmode)
      `MAMX_RM_NEAREST:
      begin
         up = g & (st | keep[0]);
         ovf_inf = 1'b1;
      end
      `MAMX_RM_ZERO:
      begin
         up = 1'b0;
         ovf_inf = 1'b0;
      end
      `MAMX_RM_PLUS:
      begin
         up = ~s & (g | st);
         ovf_inf = ~s;
      end
      default:
      begin
         up = s & (g | st);
         ovf_inf = s;
      end
   endcase
end

wire [MW+1:0] mr = {1'b0, keep} + {{(MW+1){1'b0}}, up};
wire [EW+1:0] ef = e + {{(EW+1){1'b0}}, mr[MW+1]};
wire [MW-1:0] mf = mr[MW+1] ? mr[MW:1] : mr[MW-1:0];

// special cases first, then underflow on the unrounded exponent and overflow on the rounded one
always @*
begin
   flags = 4'h0;
   y = {s, ef[EW-1:0], mf};
   if (na | nb | ((ia | ib) & (za | zb)))
   begin
      y = {1'b0, {EW{1'b1}}, 1'b1, {(MW-1){1'b0}}};
      flags[`MAMX_FX_INVALID] = ((ia | ib) & (za | zb)) |
         (na & ~ma[MW-1]) | (nb & ~mb[MW-1]);
   end
   else if (ia | ib)
   begin
      y = {s, {EW{1'b1}}, {MW{1'b0}}};
   end
   else if (za | zb)
   begin
      y = {s, {(EW+MW){1'b0}}};
   end
   else if (e[EW+1] | ~|e)
   begin
      y = {s, {(EW+MW){1'b0}}}; // tiny results flush to signed zero
      flags[`MAMX_FX_UNDERFLOW] = 1'b1;
      flags[`MAMX_FX_INEXACT] = 1'b1;
   end
   else if (ef >= EMAX)
   begin
      y = ovf_inf ? {s, {EW{1'b1}}, {MW{1'b0}}} :
         {s, {(EW-1){1'b1}}, 1'b0, {MW{1'b1}}};
      flags[`MAMX_FX_OVERFLOW] = 1'b1;
      flags[`MAMX_FX_INEXACT] = 1'b1;
   end
   else
   begin
      flags[`MAMX_FX_INEXACT] = g | st;
   end
end

endmodule // mamx_fpmul

// *** core/mamx_fpregs.v ***
// float register file: 32 x 64, two registered read ports, one write port
`timescale 1ns/1ps
`include "mamx_map.vh"
module mamx_fpregs (
   input wire clock,
   input wire rstn,
   input wire [4:0] rd_addr_a,
   input wire [4:0] rd_addr_b,
   output reg [63:0] rd_data_a,
   output reg [63:0] rd_data_b,
   input wire wr_en,
   input wire [4:0] wr_addr,
   input wire [63:0] wr_data
);

reg [63:0] mem [0:31];

// storage array carries no reset; contents are software state
always @(posedge clock)
begin
   if (wr_en)
   begin
      mem[wr_addr] <= wr_data;
   end
end

// read data registered; a write lands before a read on the next edge
always @(posedge clock or negedge rstn)
begin
   if (!rstn)
   begin
      rd_data_a <= `MAMX_RST_WORD;
      rd_data_b <= `MAMX_RST_WORD;
   end
   else
   begin
      rd_data_a <= mem[rd_addr_a];
      rd_data_b <= mem[rd_addr_b];
   end
end

endmodule // mamx_fpregs

// *** dv/mamx_exec_assertions.sv ***
// port assertions for the move and multiply unit
`timescale 1ns/1ps
module mamx_exec_assertions (
   input wire clock,
   input wire rstn,
   input wire instr_valid,
   input wire [31:0] instr,
   input wire [63:0] src_a_value,
   input wire [63:0] src_b_value,
   input wire fpu_usable,
   input wire cp2_usable,
   input wire md_wr,
   input wire instr_ready_q,
   input wire done_q,
   input wire gpr_wr_en_q,
   input wire [63:0] gpr_wr_data_q,
   input wire cp2_wr_en_q,
   input wire [31:0] cp2_wr_data_q,
   input wire [63:0] upper_product_reg_q,
   input wire [63:0] bottom_product_word_reg_q,
   input wire exc_cop_unusable_q,
   input wire [1:0] exc_cop_num_q,
   input wire exc_reserved_q,
   input wire [3:0] fp_cause_q
);
   // decoded fields of the word taken this cycle
   wire tk = instr_valid && instr_ready_q;
   wire [5:0] op = instr[31:26];
   wire [4:0] sb = instr[25:21];
   wire [31:0] bw = src_b_value[31:0];
   wire fpm = tk && op == 6'h11 && instr[5:0] == 6'h02;
   wire [63:0] pr = $signed(src_a_value[31:0]) * $signed(bw);
   wire [63:0] mx = {{32{pr[31]}}, pr[31:0]};
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);
   // a taken word, then the enable seen in its execute cycle
   sequence s_cp2(en);
      tk && op == 6'h12 && sb == 5'h04 && instr[10:3] == 8'h00
         ##1 cp2_usable == en;
   endsequence
   sequence s_pair_wr(f);
      tk && op == 6'h00 && instr[20:6] == 15'h0000 && instr[5:0] == f
         ##1 !md_wr;
   endsequence
   sequence s_mul;
      tk && op == 6'h1c && instr[10:0] == 11'h002;
   endsequence
   a_ready_turn:
   assert property (tk |=> !instr_ready_q ##1 (instr_ready_q && done_q))
      else $error("ready or done out of step");
   a_cp2_word:
   assert property (s_cp2(1'b1) |=>
      cp2_wr_en_q && cp2_wr_data_q == $past(bw, 2))
      else $error("cp2 write wrong");
   a_cop_trap:
   assert property (s_cp2(1'b0) |=> exc_cop_unusable_q
      && exc_cop_num_q == 2'h2 && !cp2_wr_en_q) else $error("cp2 trap wrong");
   a_upper_copy:
   assert property (s_pair_wr(6'h11) |=>
      upper_product_reg_q == $past(src_a_value, 2))
      else $error("upper half wrong");
   a_bottom_copy:
   assert property (s_pair_wr(6'h13) |=>
      bottom_product_word_reg_q == $past(src_a_value, 2))
      else $error("bottom half wrong");
   a_mul_word:
   assert property (s_mul |-> ##2
      (gpr_wr_en_q && gpr_wr_data_q == $past(mx, 2)))
      else $error("product word wrong");
   a_fp_badfmt:
   assert property (fpm && sb[4:1] == 4'ha ##1 fpu_usable |=> exc_reserved_q)
      else $error("bad format not refused");
   a_fp_off:
   assert property (fpm && sb == 5'h10 ##1 !fpu_usable |=> exc_cop_unusable_q
      && exc_cop_num_q == 2'h1 && $stable(fp_cause_q))
      else $error("disabled fpu not trapped");
endmodule // mamx_exec_assertions
bind mamx_exec mamx_exec_assertions u_chk (
   .clock, .rstn, .instr_valid, .instr, .src_a_value, .src_b_value,
   .fpu_usable, .cp2_usable, .md_wr, .instr_ready_q, .done_q,
   .gpr_wr_en_q, .gpr_wr_data_q, .cp2_wr_en_q, .cp2_wr_data_q,
   .upper_product_reg_q, .bottom_product_word_reg_q, .exc_cop_unusable_q,
   .exc_cop_num_q, .exc_reserved_q, .fp_cause_q
);

// *** dv/mamx_exec_tb_top.sv ***
// self-checking bench for the move and multiply unit
`timescale 1ns/1ps
module mamx_exec_tb_top;
   reg clock = 1'b0, rstn = 1'b0, instr_valid = 1'b0, go = 1'b0;
   reg fpu_usable = 1'b1, cp2_usable = 1'b1;
   reg [1:0] fp_round_mode = 2'h0;
   reg [3:0] lat = 4'h1;
   reg [31:0] instr = 32'h0, ga = 32'h0, gb = 32'h0, ra, rb;
   reg [63:0] src_a_value = 64'h0, src_b_value = 64'h0, p;
   wire md_start, md_wr, instr_ready_q, done_q, gpr_wr_en_q, cp2_wr_en_q;
   wire product_ready_q, exc_cop_unusable_q, exc_reserved_q;
   wire [63:0] md_upper, md_bottom, gpr_wr_data_q;
   wire [63:0] upper_product_reg_q, bottom_product_word_reg_q;
   wire [4:0] gpr_wr_addr_q, cp2_wr_reg_q;
   wire [2:0] cp2_wr_sel_q;
   wire [31:0] cp2_wr_data_q;
   wire [1:0] exc_cop_num_q;
   wire [3:0] fp_cause_q;
   integer n_fail = 0, checks = 0, i, k;
   // 100 ns period
   always #50 clock = ~clock;
   mamx_exec u_dut (
      .clock, .rstn, .instr_valid, .instr, .src_a_value, .src_b_value,
      .fpu_usable, .cp2_usable, .fp_round_mode, .fp_reg32_mode(1'b1),
      .md_start, .md_wr, .md_upper, .md_bottom, .instr_ready_q, .done_q,
      .gpr_wr_en_q, .gpr_wr_addr_q, .gpr_wr_data_q, .cp2_wr_en_q,
      .cp2_wr_reg_q, .cp2_wr_sel_q, .cp2_wr_data_q, .upper_product_reg_q,
      .bottom_product_word_reg_q, .product_ready_q, .exc_cop_unusable_q,
      .exc_cop_num_q, .exc_reserved_q, .fp_cause_q
   );
   mamx_md_model u_md (
      .clock, .rstn, .go, .a(ga), .b(gb), .lat, .md_start, .md_wr,
      .md_upper, .md_bottom
   );
   function [63:0] sx(input [31:0] v);
      sx = {{32{v[31]}}, v};
   endfunction
   function [63:0] smul(input [31:0] a, input [31:0] b);
      smul = $signed(a) * $signed(b);
   endfunction
   task chk(input [63:0] got, input [63:0] exp);
   begin
      checks = checks + 1;
      if (got !== exp)
      begin
         n_fail = n_fail + 1;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask
   task print_verdict;
   begin
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   end
   endtask
   // offer one word; return in the cycle its results show
   task op(input [31:0] w, input [63:0] a, input [63:0] b);
   begin
      k = 0;
      while (instr_ready_q !== 1'b1 && k < 8)
      begin
         @(posedge clock);
         #1 k = k + 1;
      end
      if (k == 8)
      begin
         n_fail = n_fail + 1;
         print_verdict;
      end
      instr = w;
      src_a_value = a;
      src_b_value = b;
      instr_valid = 1'b1;
      @(posedge clock);
      #1 instr_valid = 1'b0;
      @(posedge clock);
      #1;
   end
   endtask
   task fpw(input [4:0] idx, input [31:0] v);
      op({6'h11, 5'h04, 5'h00, idx, 11'h000}, 64'h0, {~v, v});
   endtask
   task fmul(input [4:0] f);
      op({6'h11, f, 5'h02, 5'h01, 5'h03, 6'h02}, 64'h0, 64'h0);
   endtask
   initial
   begin
      k = $urandom(32'h4c4d_3201);
      repeat (8) @(posedge clock);
      #1 rstn = 1'b1;
      @(posedge clock);
      #1;
      // word multiply, first pass is the overflow corner
      for (i = 0; i < 24; i = i + 1)
      begin
         ra = (i == 0) ? 32'h8000_0000 : $urandom;
         rb = (i == 0) ? 32'hffff_ffff : $urandom;
         p = smul(ra, rb);
         op({6'h1c, 5'h01, 5'h02, i[4:0], 11'h002}, sx(ra), sx(rb));
         chk({gpr_wr_en_q, gpr_wr_addr_q}, {1'b1, i[4:0]});
         chk(gpr_wr_data_q, sx(p[31:0]));
         chk(exc_cop_unusable_q | exc_reserved_q, 1'b0);
      end
      // product halves written back to back
      for (i = 0; i < 8; i = i + 1)
      begin
         ra = $urandom;
         rb = $urandom;
         op({6'h00, ra[4:0], 15'h0000, 6'h11}, {ra, rb}, 64'h0);
         op({6'h00, rb[4:0], 15'h0000, 6'h13}, {rb, ra}, 64'h0);
         chk(bottom_product_word_reg_q, {rb, ra});
         chk(upper_product_reg_q, {ra, rb});
      end
      // external result, prompt then slow, read before overwrite
      for (i = 0; i < 2; i = i + 1)
      begin
         ga = $urandom;
         gb = $urandom;
         lat = i ? 4'hc : 4'h1;
         go = 1'b1;
         @(posedge clock);
         #1 go = 1'b0;
         @(posedge clock);
         #1 chk(product_ready_q, 1'b0);
         k = 0;
         while (product_ready_q !== 1'b1 && k < 40)
         begin
            @(posedge clock);
            #1 k = k + 1;
         end
         chk(k < 40, 1'b1);
         p = smul(ga, gb);
         chk(upper_product_reg_q, sx(p[63:32]));
         chk(bottom_product_word_reg_q, sx(p[31:0]));
         op({6'h00, 5'h03, 15'h0000, 6'h11}, {gb, ga}, 64'h0);
      end
      // cp2 moves enabled, then with the coprocessor off
      for (i = 0; i < 10; i = i + 1)
      begin
         ra = $urandom;
         // far registers below 8 take no selector, so the stream sends 0
         rb = (ra[4:3] == 2'b00) ? 32'h0 : {29'h0, ra[12:10]};
         cp2_usable = (i < 8);
         op({6'h12, 5'h04, ra[9:5], ra[4:0], 8'h00, rb[2:0]}, 64'h0,
            {~ra, ra});
         if (i < 8)
            chk({cp2_wr_en_q, cp2_wr_reg_q, cp2_wr_sel_q, cp2_wr_data_q},
               {1'b1, ra[4:0], rb[2:0], ra});
         else
            chk({exc_cop_unusable_q, exc_cop_num_q, cp2_wr_en_q},
               4'hc);
      end
      cp2_usable = 1'b1;
      // float multiply right after the moves, every rounding mode
      for (i = 0; i < 4; i = i + 1)
      begin
         fp_round_mode = i[1:0];
         fpw(5'h01, 32'h7f00_0000);
         fpw(5'h02, 32'h7f00_0000);
         fmul(5'h10);
         chk(fp_cause_q, 4'h5);
         fmul(5'h16);
         chk(fp_cause_q, 4'h5);
      end
      fpw(5'h01, 32'h7f80_0000);
      fpw(5'h02, 32'h0);
      fmul(5'h10);
      chk(fp_cause_q, 4'h8);
      fpu_usable = 1'b0;
      fmul(5'h10);
      chk({exc_cop_unusable_q, exc_cop_num_q, fp_cause_q}, 7'h58);
      fpw(5'h01, 32'h3f80_0000);
      chk({exc_cop_unusable_q, exc_cop_num_q}, 3'h5);
      fpu_usable = 1'b1;
      fmul(5'h10);
      chk(fp_cause_q, 4'h8);
      for (i = 0; i < 2; i = i + 1)
      begin
         fmul(5'h14 + i[4:0]);
         chk({exc_reserved_q, fp_cause_q}, 5'h18);
      end
      print_verdict;
   end
endmodule // mamx_exec_tb_top

// *** dv/mamx_md_model.sv ***
// behavioural external multiply unit that fills the product pair
`timescale 1ns/1ps
module mamx_md_model (
   input wire clock,
   input wire rstn,
   input wire go,
   input wire [31:0] a,
   input wire [31:0] b,
   input wire [3:0] lat,
   output reg md_start,
   output reg md_wr,
   output reg [63:0] md_upper,
   output reg [63:0] md_bottom
);
   reg [3:0] cnt_q;
   reg [63:0] p_q;
   // result lands lat cycles after launch; idle data lines toggle
   always @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         md_start <= 1'b0;
         md_wr <= 1'b0;
         cnt_q <= 4'h0;
         p_q <= 64'h0;
         md_upper <= 64'h0;
         md_bottom <= 64'h0;
      end
      else
      begin
         md_start <= go;
         md_wr <= (cnt_q == 4'h1);
         cnt_q <= go ? lat : cnt_q - {3'h0, cnt_q != 4'h0};
         if (go)
            p_q <= $signed(a) * $signed(b);
         md_upper <= (cnt_q == 4'h1) ? {{32{p_q[63]}}, p_q[63:32]} :
            ~md_upper;
         md_bottom <= (cnt_q == 4'h1) ? {{32{p_q[31]}}, p_q[31:0]} :
            ~md_bottom;
      end
   end
endmodule // mamx_md_model

// *** pkg/mamx_map.vh ***
// encodings, field positions and reset values for the move/multiply unit
`ifndef MAMX_MAP_VH
`define MAMX_MAP_VH

// instruction field positions
`define MAMX_OP_MSB 31
`define MAMX_OP_LSB 26
`define MAMX_SUB_MSB 25
`define MAMX_SUB_LSB 21
`define MAMX_SRCB_MSB 20
`define MAMX_SRCB_LSB 16
`define MAMX_RD_MSB 15
`define MAMX_RD_LSB 11
`define MAMX_FDEST_MSB 10
`define MAMX_FDEST_LSB 6
`define MAMX_FN_MSB 5
`define MAMX_FN_LSB 0

// major opcodes
`define MAMX_OP_SPECIAL 6'h00
`define MAMX_OP_FPU_GROUP 6'h11
`define MAMX_OP_CP2_GROUP 6'h12
`define MAMX_OP_SECOND_SPECIAL_OPCODE_GROUP 6'h1C

// sub-op and function codes
`define MAMX_MOVE_TO_SUBOP 5'h04
`define MAMX_FN_WR_UPPER 6'h11
`define MAMX_FN_WR_BOTTOM 6'h13
`define MAMX_FN_PROD_TO_REG 6'h02
`define MAMX_FN_FP_PRODUCT 6'h02

// float formats
`define MAMX_FMT_SINGLE 5'h10
`define MAMX_FMT_DOUBLE 5'h11
`define MAMX_FMT_PAIRED 5'h16

// rounding modes
`define MAMX_RM_NEAREST 2'h0
`define MAMX_RM_ZERO 2'h1
`define MAMX_RM_PLUS 2'h2
`define MAMX_RM_MINUS 2'h3

// fp cause bit positions
`define MAMX_FX_INVALID 3
`define MAMX_FX_OVERFLOW 2
`define MAMX_FX_UNDERFLOW 1
`define MAMX_FX_INEXACT 0

// reset values
`define MAMX_RST_WORD 64'h0000_0000_0000_0000
`define MAMX_RST_COP_NUM 2'h0

`endif
